// file: acwd_pkg.sv
package acwd_pkg;

    // Serial word and frame lengths
    localparam int WORD_BITS  = 16;
    localparam int FRAME_BITS = 24;
    localparam int CNT_W      = 5;

    // Prefix codes (two preamble bits plus write flag)
    localparam logic [2:0] PFX_KEEP_A = 3'h0;
    localparam logic [2:0] PFX_KEEP_B = 3'h4;
    localparam logic [2:0] PFX_LOAD   = 3'h5;

    // Field positions inside the captured word, first bit in is bit 15
    localparam int POS_PFX_HI    = 15;
    localparam int POS_PFX_LO    = 13;
    localparam int POS_SINGLE    = 12;
    localparam int POS_POLARITY  = 11;
    localparam int POS_ADDR_HI   = 10;
    localparam int POS_ADDR_LO   = 8;
    localparam int POS_SETUP_LD  = 7;
    localparam int POS_TEMP_SEL  = 6;
    localparam int POS_REJ_HI    = 5;
    localparam int POS_REJ_LO    = 4;
    localparam int POS_DBL_RATE  = 3;
    localparam int POS_GAIN_HI   = 2;
    localparam int POS_GAIN_LO   = 0;

    // Rejection mode encodings
    localparam logic [1:0] REJ_BOTH = 2'h0;
    localparam logic [1:0] REJ_50   = 2'h1;
    localparam logic [1:0] REJ_60   = 2'h2;

    // Input selector codes; 4 is the shared negative input
    localparam logic [2:0] SHARED_NEG_CODE = 3'h4;

    // Values after reset
    localparam logic       RST_SINGLE   = 1'b0;
    localparam logic       RST_POLARITY = 1'b0;
    localparam logic [2:0] RST_ADDR     = 3'h0;
    localparam logic       RST_TEMP_SEL = 1'b0;
    localparam logic [1:0] RST_REJ      = REJ_BOTH;
    localparam logic       RST_DBL_RATE = 1'b0;
    localparam logic [2:0] RST_GAIN     = 3'h0;
    localparam logic [2:0] RST_POS_IN   = 3'h0;
    localparam logic [2:0] RST_NEG_IN   = 3'h1;
    localparam logic [8:0] RST_GAIN_VAL = 9'h001;

    // Conversion time of the stand-in converter timer
    localparam int CLK_PERIOD_NS = 5;
    localparam int CONV_TIME_NS  = 5000;
    localparam int CONV_CYCLES   = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int TMR_W         = 12;

    // Converter cycle states
    typedef enum logic [1:0] {ST_CONV, ST_SLEEP, ST_OUT} acwd_state_e;

endpackage

// file: acwd_decoder.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Sixteen-bit word: channel group, setup group
// - Reset: input0 minus input1, both notches, 1x, gain1
// - First conversion automatic; words only after it
// - Prefix 000/100: keep channel and setup
// - Prefix 101: next five bits pick mux
// - First bit: differential or single-ended, shared negative
// - Low address picks pair; polarity swaps or odd
// - Setup load flag zero keeps stored setup
// - Flag one loads seven bits; sensor select first
// - Rejection code: 00 both, 01 50Hz, 10 60Hz
// - Speed bit: 0 is 1x, 1 is 2x
// - Sensor selected: ignore speed and gain, 1x
// - 1x gain codes: 1,4,8,...,256
// - 2x gain codes: 1,2,4,...,128
// - Setup kept until prefix 101 with flag set
// - Result clamps at plus and minus full scale
// - Sign at zero code free only at 2x
// - Bits taken on rising serial clock, select low
// - Conversion starts after 24 bits or abort
module acwd_decoder
    import acwd_pkg::*;
(
    input  wire logic        clock_i,           // System clock, 200 MHz
    input  wire logic        rst_i,             // Reset; synchronous in the clock_i domain, asynchronous in the sck domain
    input  wire logic        sck_i,             // Serial clock from host
    input  wire logic        cs_n_i,            // Chip select, active low
    input  wire logic        sdi_i,             // Serial data in
    input  wire logic        conv_sign_i,       // Converter sign
    input  wire logic [16:0] conv_code_i,       // Converter result bits
    input  wire logic        conv_over_i,       // Above full scale
    input  wire logic        conv_under_i,      // Below negative full scale
    output logic             conv_start_o,      // Conversion start pulse
    output logic             eoc_n_o,           // High while converting
    output logic [2:0]       pos_input_o,       // Positive input select
    output logic [2:0]       neg_input_o,       // Negative input select
    output logic             temp_sensor_sel_o, // Internal sensor measured
    output logic [1:0]       reject_mode_o,     // Line rejection mode
    output logic             double_rate_sel_o, // Effective 2x rate
    output logic [2:0]       gain_code_o,       // Effective gain code
    output logic [8:0]       gain_o,            // Effective gain value
    output logic [23:0]      result_word_o      // Coded output frame
);

    // Gain from code and rate
    function automatic logic [8:0] gain_value(input logic dbl,
                                              input logic [2:0] code);
        logic [8:0] g;
        g = 9'h001;
        if (code != 3'h0)
        begin
            g = dbl ? 9'(9'h001 << code)
                    : 9'(9'h002 << code);
        end
        return g;
    endfunction

    // Output frame from converter state
    function automatic logic [23:0] code_frame(input logic sgn,
                                               input logic [16:0] code,
                                               input logic over,
                                               input logic under,
                                               input logic dbl);
        logic [23:0] f;
        f = 24'h000000;
        if (over)
        begin
            f = {3'h1, 1'b1, 16'h0000, 4'h0};
        end
        else if (under)
        begin
            f = {3'h0, 1'b0, 16'hffff, 4'h0};
        end
        else if (code == 17'h00000 && !dbl)
        begin
            f = {3'h1, code, 4'h0};
        end
        else
        begin
            f = {2'h0, sgn, code, 4'h0};
        end
        return f;
    endfunction

    // ---------------- Serial clock domain ----------------
    logic [CNT_W-1:0]     sck_cnt_q;   // Rising edges this frame
    logic [WORD_BITS-1:0] shift_q;     // Incoming bits
    logic [WORD_BITS-1:0] word_q;      // Last complete word
    logic                 word_tgl_q;  // Flips per complete word
    logic                 done_tgl_q;  // Flips on 24th edge
    logic                 first_tgl_q; // Flips on first edge

    // Edge counter; chip select high ends the frame, as sck may stop
    always_ff @(posedge sck_i or posedge cs_n_i)
    begin
        if (cs_n_i)
        begin
            sck_cnt_q <= '0;
        end
        else if (sck_cnt_q != CNT_W'(FRAME_BITS))
        begin
            sck_cnt_q <= sck_cnt_q + CNT_W'(1);
        end
    end

    // Shift in on the first sixteen rising edges of the frame
    always_ff @(posedge sck_i)
    begin
        if (sck_cnt_q < CNT_W'(WORD_BITS))
        begin
            shift_q <= {shift_q[WORD_BITS-2:0], sdi_i};
        end
    end

    // Toggles for the clock crossing; reset must not wait for sck
    always_ff @(posedge sck_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            word_q      <= '0;
            word_tgl_q  <= 1'b0;
            done_tgl_q  <= 1'b0;
            first_tgl_q <= 1'b0;
        end
        else
        begin
            if (sck_cnt_q == CNT_W'(0))
            begin
                first_tgl_q <= ~first_tgl_q;
            end
            // Sixteenth bit completes the word
            if (sck_cnt_q == CNT_W'(WORD_BITS - 1))
            begin
                word_q     <= {shift_q[WORD_BITS-2:0], sdi_i};
                word_tgl_q <= ~word_tgl_q;
            end
            if (sck_cnt_q == CNT_W'(FRAME_BITS - 1))
            begin
                done_tgl_q <= ~done_tgl_q;
            end
        end
    end

    // ---------------- System clock domain ----------------
    logic [3:0] cs_s_q;    // Select synchroniser, one stage extra
    logic [2:0] word_s_q;  // Word toggle synchroniser
    logic [2:0] done_s_q;  // Frame done synchroniser
    logic [2:0] first_s_q; // First edge synchroniser
    logic       word_evt;  // Word has arrived
    logic       done_evt;  // All frame bits read
    logic       first_evt; // Frame has begun clocking
    logic       cs_rise;   // Select released

    // Stage 0 feeds only stage 1
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            cs_s_q    <= 4'hf;
            word_s_q  <= 3'h0;
            done_s_q  <= 3'h0;
            first_s_q <= 3'h0;
        end
        else
        begin
            cs_s_q    <= {cs_s_q[2:0], cs_n_i};
            word_s_q  <= {word_s_q[1:0], word_tgl_q};
            done_s_q  <= {done_s_q[1:0], done_tgl_q};
            first_s_q <= {first_s_q[1:0], first_tgl_q};
        end
    end

    // Release seen one cycle late so a word never loses the race
    assign cs_rise   = cs_s_q[2] & ~cs_s_q[3];
    assign word_evt  = word_s_q[1] ^ word_s_q[2];
    assign done_evt  = done_s_q[1] ^ done_s_q[2];
    assign first_evt = first_s_q[1] ^ first_s_q[2];

    acwd_state_e      state_q;  // Converter cycle state
    logic [TMR_W-1:0] tmr_q;    // Conversion timer
    logic             edged_q;  // Frame saw a rising edge
    logic             start;    // Conversion begins this edge
    logic             conv_end; // Conversion completes this edge

    assign start = (state_q == ST_OUT)
                   && (done_evt || (cs_rise && (edged_q || first_evt)));
    assign conv_end = (state_q == ST_CONV)
                      && (tmr_q == TMR_W'(CONV_CYCLES - 1));

    // Converter cycle; reset starts a conversion at once
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            state_q <= ST_CONV;
        end
        else
        begin
            unique case (state_q)
                ST_CONV:
                begin
                    if (conv_end)
                    begin
                        state_q <= ST_SLEEP;
                    end
                end
                ST_SLEEP:
                begin
                    // Select low after completion opens the frame
                    if (!cs_s_q[2])
                    begin
                        state_q <= ST_OUT;
                    end
                end
                ST_OUT:
                begin
                    if (start)
                    begin
                        state_q <= ST_CONV;
                    end
                    else if (cs_rise)
                    begin
                        state_q <= ST_SLEEP;
                    end
                end
            endcase
        end
    end

    // Conversion timer and frame edge flag
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            tmr_q   <= '0;
            edged_q <= 1'b0;
        end
        else
        begin
            tmr_q   <= (state_q == ST_CONV && !conv_end)
                       ? tmr_q + TMR_W'(1) : '0;
            // Also armed in sleep: a quick first edge can beat the
            // slower select synchroniser into the frame state
            edged_q <= (state_q != ST_CONV) && !cs_rise
                       && (edged_q || first_evt);
        end
    end

    // Pending word fields
    logic       pend_single_q;   // single_ended_sel
    logic       pend_polarity_q; // Polarity or odd channel
    logic [2:0] pend_addr_q;     // mux_addr_bit2..0
    logic       pend_temp_q;     // temp_sensor_sel
    logic [1:0] pend_rej_q;      // reject_sel_hi, reject_sel_lo
    logic       pend_dbl_q;      // double_rate_sel
    logic [2:0] pend_gain_q;     // gain_code_b2..b0
    logic       take;            // Word accepted

    // Words during a conversion are dropped
    assign take = word_evt && (state_q == ST_OUT);

    // Decode prefix and groups
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            pend_single_q   <= RST_SINGLE;
            pend_polarity_q <= RST_POLARITY;
            pend_addr_q     <= RST_ADDR;
            pend_temp_q     <= RST_TEMP_SEL;
            pend_rej_q      <= RST_REJ;
            pend_dbl_q      <= RST_DBL_RATE;
            pend_gain_q     <= RST_GAIN;
        end
        // Other prefixes keep everything too
        else if (take && word_q[POS_PFX_HI:POS_PFX_LO] == PFX_LOAD)
        begin
            pend_single_q   <= word_q[POS_SINGLE];
            pend_polarity_q <= word_q[POS_POLARITY];
            pend_addr_q     <= word_q[POS_ADDR_HI:POS_ADDR_LO];
            if (word_q[POS_SETUP_LD])
            begin
                pend_temp_q <= word_q[POS_TEMP_SEL];
                pend_rej_q  <= word_q[POS_REJ_HI:POS_REJ_LO];
                pend_dbl_q  <= word_q[POS_DBL_RATE];
                pend_gain_q <= word_q[POS_GAIN_HI:POS_GAIN_LO];
            end
        end
    end

    // Apply pending setup only as a conversion starts
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            pos_input_o       <= RST_POS_IN;
            neg_input_o       <= RST_NEG_IN;
            temp_sensor_sel_o <= RST_TEMP_SEL;
            reject_mode_o     <= RST_REJ;
            double_rate_sel_o <= RST_DBL_RATE;
            gain_code_o       <= RST_GAIN;
            gain_o            <= RST_GAIN_VAL;
        end
        else if (start)
        begin
            // Pair base is 0 or 2; upper address bits unused
            pos_input_o <= {1'b0, pend_addr_q[0],
                            pend_polarity_q};
            if (pend_single_q)
            begin
                neg_input_o <= SHARED_NEG_CODE;
            end
            else
            begin
                neg_input_o <= {1'b0, pend_addr_q[0], ~pend_polarity_q};
            end
            temp_sensor_sel_o <= pend_temp_q;
            reject_mode_o     <= pend_rej_q;
            // Sensor forces 1x and unity gain
            double_rate_sel_o <= pend_dbl_q & ~pend_temp_q;
            gain_code_o <= pend_temp_q ? 3'h0 : pend_gain_q;
            gain_o      <= pend_temp_q ? 9'h001
                           : gain_value(pend_dbl_q, pend_gain_q);
        end
    end

    // Start pulse, busy flag and coded result
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            conv_start_o  <= 1'b1;
            eoc_n_o       <= 1'b1;
            result_word_o <= '0;
        end
        else
        begin
            conv_start_o <= start;
            if (conv_end)
            begin
                eoc_n_o       <= 1'b0;
                result_word_o <= code_frame(conv_sign_i, conv_code_i,
                                            conv_over_i, conv_under_i,
                                            double_rate_sel_o);
            end
            else if (start)
            begin
                eoc_n_o <= 1'b1;
            end
        end
    end

    // ---------------- Checks ----------------
    sequence s_taken_keep;
        take && word_q[POS_PFX_HI:POS_PFX_LO] != PFX_LOAD;
    endsequence

    sequence s_taken_chan_only;
        take && word_q[POS_PFX_HI:POS_PFX_LO] == PFX_LOAD
        && !word_q[POS_SETUP_LD];
    endsequence

    AST_RESET_SETUP: assert property (@(posedge clock_i)
        disable iff (rst_i) $past(rst_i) |-> pos_input_o == 3'h0
        && neg_input_o == 3'h1 && gain_o == 9'h001 && !double_rate_sel_o)
        else $error("reset setup wrong");
    AST_FIRST_CONV: assert property (@(posedge clock_i)
        disable iff (rst_i) state_q == ST_CONV && word_evt
        |=> $stable(pend_addr_q) && $stable(pend_gain_q))
        else $error("word taken during conversion");
    AST_KEEP_PREFIX: assert property (@(posedge clock_i)
        disable iff (rst_i) s_taken_keep
        |=> $stable({pend_single_q, pend_addr_q, pend_rej_q, pend_gain_q}))
        else $error("keep prefix changed setup");
    AST_LOAD_CHAN: assert property (@(posedge clock_i)
        disable iff (rst_i)
        take && word_q[POS_PFX_HI:POS_PFX_LO] == PFX_LOAD
        |=> pend_addr_q == $past(word_q[POS_ADDR_HI:POS_ADDR_LO]))
        else $error("channel not loaded");
    AST_SE_NEG: assert property (@(posedge clock_i)
        disable iff (rst_i) start && pend_single_q
        |=> neg_input_o == SHARED_NEG_CODE)
        else $error("single-ended negative wrong");
    AST_SETUP_KEPT: assert property (@(posedge clock_i)
        disable iff (rst_i) s_taken_chan_only
        |=> $stable({pend_temp_q, pend_rej_q, pend_dbl_q, pend_gain_q}))
        else $error("setup changed without load flag");
    AST_TEMP_RATE: assert property (@(posedge clock_i)
        disable iff (rst_i) temp_sensor_sel_o
        |-> !double_rate_sel_o && gain_o == 9'h001)
        else $error("sensor not at 1x unity gain");
    AST_GAIN_2X: assert property (@(posedge clock_i)
        disable iff (rst_i) double_rate_sel_o
        |-> gain_o == 9'(9'h001 << gain_code_o))
        else $error("2x gain wrong");
    AST_HOLD_SETUP: assert property (@(posedge clock_i)
        disable iff (rst_i) !start |=> $stable(pos_input_o)
        && $stable(gain_o) && $stable(reject_mode_o))
        else $error("setup changed mid conversion");
    AST_OVER_CODE: assert property (@(posedge clock_i)
        disable iff (rst_i) conv_end && conv_over_i
        |=> result_word_o == 24'h300000 && !eoc_n_o)
        else $error("over-range code wrong");
    AST_FRAME_START: assert property (@(posedge clock_i)
        disable iff (rst_i) state_q == ST_OUT && done_evt
        |=> conv_start_o && eoc_n_o ##1 !conv_start_o)
        else $error("no conversion after full read");

endmodule // acwd_decoder

// file: acwd_host.sv
`timescale 1ns/1ps
// Host on the far side of the link; its clock runs only inside frames
module acwd_host
(
    output logic sck_o,  // Serial clock, idle low
    output logic cs_n_o, // Select, active low
    output logic sdi_o   // Serial data, word bit 15 first
);
    // Idle levels from time zero
    initial
    begin
        sck_o  = 1'b0;
        cs_n_o = 1'b1;
        sdi_o  = 1'b0;
    end

    // One frame of n bits at a 12 ns period, phase free of the system clock
    task automatic send(input logic [23:0] bits, input int n);
        #3.3 cs_n_o = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            sdi_o = bits[23-i];   // Bit set up half a period early
            #6 sck_o = 1'b1;      // Taken by the device here
            #6 sck_o = 1'b0;
        end
        #6 cs_n_o = 1'b1;         // Full frame or early abort
        sdi_o = ~sdi_o;           // Released line never shows the last bit
        #30;                      // Select high for several system clocks
    endtask
endmodule // acwd_host

// file: acwd_decoder_test.sv
`timescale 1ns/1ps
module acwd_decoder_test
    import acwd_pkg::*;
();
    logic        clock_i;     // System clock
    logic        rst_i;       // Synchronous reset
    logic        sck;         // Link clock
    logic        cs_n;        // Link select
    logic        sdi;         // Link data
    logic        conv_sign;   // Stand-in converter sign
    logic [16:0] conv_code;   // Stand-in converter code
    logic        conv_over;   // Above full scale
    logic        conv_under;  // Below negative full scale
    logic        conv_start;  // Start pulse
    logic        eoc_n;       // Busy level
    logic        eoc_prev;    // Busy level one cycle back
    logic [2:0]  pos_in;      // Positive selector
    logic [2:0]  neg_in;      // Negative selector
    logic        temp_sel;    // Sensor measured
    logic [1:0]  rej;         // Rejection mode
    logic        dbl_sel;     // Effective 2x rate
    logic [2:0]  gain_code;   // Effective gain code
    logic [8:0]  gain;        // Numeric gain
    logic [23:0] result_word; // Coded result
    logic [4:0]  chan;        // Model: single, odd, address
    logic [6:0]  setup;       // Model: sensor, rejection, speed, gain
    logic [21:0] held;        // Setup outputs since the last start
    logic        armed;       // Start monitor live
    logic [31:0] r;           // Random draw
    logic [15:0] word;        // Word to send
    int          n;           // Edges in the frame
    int          seed;
    int          cycles;
    int          fail_count;
    int          comparisons;
    logic [21:0] setup_q[$];  // Expected outputs at each start
    logic [23:0] result_q[$]; // Expected frame at each result
    wire  [23:0] seen = {1'b0, eoc_n, pos_in, neg_in, temp_sel, rej,
                         dbl_sel, gain_code, gain};

    acwd_decoder i_dut (
        .clock_i(clock_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n),
        .sdi_i(sdi), .conv_sign_i(conv_sign), .conv_code_i(conv_code),
        .conv_over_i(conv_over), .conv_under_i(conv_under),
        .conv_start_o(conv_start), .eoc_n_o(eoc_n), .pos_input_o(pos_in),
        .neg_input_o(neg_in), .temp_sensor_sel_o(temp_sel),
        .reject_mode_o(rej), .double_rate_sel_o(dbl_sel),
        .gain_code_o(gain_code), .gain_o(gain), .result_word_o(result_word)
    );

    acwd_host i_host (.sck_o(sck), .cs_n_o(cs_n), .sdi_o(sdi));

    // Outputs the model expects from the stored fields
    function automatic logic [21:0] expect_setup();
        logic [2:0] base;
        logic [2:0] gc;
        logic       dbl;
        base = {1'b0, chan[0], 1'b0};           // Pair 0/1 or 2/3
        dbl  = setup[3] & ~setup[6];
        gc   = setup[6] ? 3'h0 : setup[2:0];
        return {base + {2'h0, chan[3]},
                chan[4] ? SHARED_NEG_CODE : base + {2'h0, ~chan[3]},
                setup[6], setup[5:4], dbl, gc,
                9'h001 << ({1'b0, gc} + 4'(~dbl & (gc != 3'h0)))};
    endfunction

    // Coded result for the converter values now driven
    function automatic logic [23:0] expect_result(input logic dbl);
        if (conv_over)
            return 24'h300000;
        if (conv_under)
            return 24'h0ffff0;
        return {2'h0, conv_sign | (~dbl & (conv_code == 17'h0)),
                conv_code, 4'h0};
    endfunction

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        if (fail_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Bounded wait for a finished conversion
    task automatic wait_ready();
        for (int i = 0; i < 1200 && eoc_n !== 1'b0; i++)
            @(negedge clock_i);
        if (eoc_n !== 1'b0)
            fail_count++;                       // Limit ran out
    endtask

    // New converter values for the conversion just started
    task automatic new_result();
        logic [21:0] e;
        e = expect_setup();
        r = $random(seed);
        @(posedge clock_i);
        conv_over  <= (r[1:0] == 2'h0);
        conv_under <= (r[1:0] == 2'h1);
        conv_code  <= (r[1:0] == 2'h2) ? 17'h0 : r[18:2];
        conv_sign  <= r[20];
        @(negedge clock_i);
        result_q.push_back(expect_result(e[12]));
    endtask

    // Send one frame and note what it should leave behind
    task automatic frame(input logic [15:0] w, input int nb);
        if (nb >= 16 && w[15:13] == PFX_LOAD)
        begin
            chan = w[12:8];
            if (w[7])
                setup = w[6:0];
        end
        if (nb > 0)
            setup_q.push_back(expect_setup());
        i_host.send({w, r[31:24]}, nb);
        for (int i = 0; i < 40 && setup_q.size() != 0; i++)
            @(negedge clock_i);
        if (setup_q.size() != 0)
            fail_count++;                       // Start never seen
        if (nb > 0)
            new_result();
    endtask

    // System clock
    initial
    begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    // Hang guard
    always @(posedge clock_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 70000)
        begin
            fail_count++;
            print_verdict();
        end
    end

    // Result watcher, off the sampling edge
    always @(negedge clock_i)
    begin
        if (!rst_i && armed && conv_start === 1'b1)
        begin
            check(seen, setup_q.size() ? {2'h1, setup_q.pop_front()} :
                  24'hx);
            held = seen[21:0];
        end
        else if (armed && seen[21:0] !== held)
            check({2'h0, seen[21:0]}, {2'h0, held});
        if (!rst_i && eoc_prev === 1'b1 && eoc_n === 1'b0)
            check(result_word, result_q.size() ? result_q.pop_front() :
                  24'hx);
        eoc_prev = eoc_n;
    end

    // Main sequence
    initial
    begin
        seed = 32;
        rst_i = 1'b1;
        {conv_sign, conv_code, conv_over, conv_under} = '0;
        {chan, setup, armed, cycles, fail_count, comparisons} = '0;
        eoc_prev = 1'b0;
        repeat (8) @(posedge clock_i);
        rst_i <= 1'b0;
        result_q.push_back(expect_result(1'b0));
        @(negedge clock_i);
        check(seen, {2'h1, expect_setup()});
        repeat (3) @(negedge clock_i);
        held = seen[21:0];
        armed = 1'b1;
        // Word during the first conversion leaves everything alone
        i_host.send({16'hbfff, 8'h00}, 24);
        // Keep word next, so a wrongly taken word would show up
        r = $random(seed);
        wait_ready();
        frame({PFX_KEEP_B, 13'h1fff}, 24);
        // Every gain code at both rates, rejection codes in turn
        for (int k = 0; k < 16; k++)
        begin
            r = $random(seed);
            wait_ready();
            frame({PFX_LOAD, r[1:0], 2'h0, r[2], 2'b10, 2'(k % 3),
                   k[3], k[2:0]}, 24);
        end
        // Mixed prefixes, sensor, aborts and empty selects
        for (int k = 0; k < 28; k++)
        begin
            r = $random(seed);
            word = {PFX_LOAD, r[3:2], 2'h0, r[4], r[6:5],
                    (r[8:7] == 2'h3) ? 2'h0 : r[8:7], r[12:9]};
            if (r[1] == 1'b0)
                word = {r[0] ? PFX_KEEP_B : PFX_KEEP_A, r[28:16]};
            n = (r[15:14] == 2'h0) ? int'(r[19:16]) :
                (r[15:14] == 2'h1) ? 16 + int'(r[22:20]) : 24;
            wait_ready();
            frame(word, n);
        end
        wait_ready();
        repeat (4) @(negedge clock_i);
        // Notes left over mean starts or results that never came
        check(24'(setup_q.size()), 24'h0);
        check(24'(result_q.size()), 24'h0);
        print_verdict();
    end
endmodule // acwd_decoder_test
